// ### hdl/prx_router.sv
// prx_router: route registers and slot selection for receive channels 4-6
`timescale 1ns/100ps
`default_nettype none
// Functional notes
// - channel 4 enable bit 5 feeds playback
// - slot field bits 4-0 picks TDM slot
// - I2S/LJ: 0-15 left, 16-31 right half
// - slot defaults: 3, 4, 5 for channels 4-6
// - channel 5 source: off, playback, loopback, reserved
// - channel 6 source: off, playback, loopback, link
// - all three channels disabled after reset
module prx_router (
    // system clock and reset
    input  wire logic                          clock,
    input  wire logic                          arst_n,
    // register port
    input  wire logic [7:0]                    reg_addr,
    input  wire logic                          reg_wr,
    input  wire logic [7:0]                    reg_wdata,
    output logic [7:0]                         reg_rdata,
    // port framing choice
    input  wire prx_pkg::prx_fmt_t             frame_format,
    // serial link, own clock
    input  wire logic                          link_clk,
    input  wire logic                          link_fsync,
    input  wire logic                          link_din,
    // received words, one per channel 4..6
    output var prx_pkg::prx_sample_t [2:0]     sample,
    output logic [2:0]                         sample_valid
);
    localparam int N = prx_pkg::NUM_CH;

    logic [7:0] ch4_route;              // channel 4 register
    logic [7:0] ch5_route;              // channel 5 register
    logic [7:0] ch6_route;              // channel 6 register
    logic       any_wr_seen;            // helper: a write has happened

    // address decode
    wire hit4 = reg_addr == prx_pkg::CH4_ROUTE_ADDR;
    wire hit5 = reg_addr == prx_pkg::CH5_ROUTE_ADDR;
    wire hit6 = reg_addr == prx_pkg::CH6_ROUTE_ADDR;
    // read mux, unmapped reads return zero
    wire [7:0] next_rdata = hit4 ? ch4_route :
                            hit5 ? ch5_route :
                            hit6 ? ch6_route : 8'h00;

    // register writes; reserved bits are masked off
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            ch4_route   <= prx_pkg::CH4_ROUTE_RST;
            ch5_route   <= prx_pkg::CH5_ROUTE_RST;
            ch6_route   <= prx_pkg::CH6_ROUTE_RST;
            reg_rdata   <= 8'h00;
            any_wr_seen <= 1'b0;
        end else begin
            reg_rdata <= next_rdata;
            if (reg_wr && hit4) ch4_route <= reg_wdata & prx_pkg::CH4_WR_MASK;
            if (reg_wr && hit5) ch5_route <= reg_wdata & prx_pkg::CH56_WR_MASK;
            if (reg_wr && hit6) ch6_route <= reg_wdata & prx_pkg::CH56_WR_MASK;
            if (reg_wr) any_wr_seen <= 1'b1;
        end
    end

    // decode sources into destinations
    wire [1:0] src5 = ch5_route[prx_pkg::SRC_LSB +: 2];
    wire [1:0] src6 = ch6_route[prx_pkg::SRC_LSB +: 2];
    prx_pkg::prx_route_t [N-1:0] route;
    assign route[0].dest = ch4_route[prx_pkg::ENABLE_BIT] ?
                           prx_pkg::PRX_DEST_PLAYBACK : prx_pkg::PRX_DEST_NONE;
    // code 3 of channel 5 has no meaning; it is parked as disabled
    assign route[1].dest = (src5 == 2'h3) ? prx_pkg::PRX_DEST_NONE :
                           prx_pkg::prx_dest_t'(src5);
    assign route[2].dest = prx_pkg::prx_dest_t'(src6);
    assign route[0].slot = ch4_route[prx_pkg::SLOT_LSB +: prx_pkg::SLOT_W];
    assign route[1].slot = ch5_route[prx_pkg::SLOT_LSB +: prx_pkg::SLOT_W];
    assign route[2].slot = ch6_route[prx_pkg::SLOT_LSB +: prx_pkg::SLOT_W];
    wire prx_pkg::prx_link_cfg_t cfg_now = '{fmt: frame_format, ch: route};

    // config crossing: four-phase-free toggle handshake on a held word
    prx_pkg::prx_link_cfg_t cfg_hold;   // stable while a request is out
    prx_pkg::prx_link_cfg_t cfg_link;   // copy used on the link
    logic req, ack;                     // toggles
    logic ack_m1, ack_m2;               // ack into clock domain
    logic req_l1, req_l2;               // req into link domain
    logic lrst_m1, link_rst_n;          // link reset release sync
    wire  idle = ack_m2 == req;

    // send a fresh copy whenever the settings move and the path is idle
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            cfg_hold <= '0;
            req      <= 1'b0;
            ack_m1   <= 1'b0;
            ack_m2   <= 1'b0;
        end else begin
            ack_m1 <= ack;
            ack_m2 <= ack_m1;
            if (idle && cfg_hold != cfg_now) begin
                cfg_hold <= cfg_now;
                req      <= ~req;
            end
        end
    end

    // link reset: asserted at once, released on the link clock
    always_ff @(posedge link_clk or negedge arst_n) begin
        if (!arst_n) begin
            lrst_m1    <= 1'b0;
            link_rst_n <= 1'b0;
        end else begin
            lrst_m1    <= 1'b1;
            link_rst_n <= lrst_m1;
        end
    end

    // link side of the handshake
    always_ff @(posedge link_clk or negedge link_rst_n) begin
        if (!link_rst_n) begin
            req_l1   <= 1'b0;
            req_l2   <= 1'b0;
            ack      <= 1'b0;
            cfg_link <= '0;
        end else begin
            req_l1 <= req;
            req_l2 <= req_l1;
            if (req_l2 != ack) begin
                cfg_link <= cfg_hold;
                ack      <= req_l2;
            end
        end
    end

    // frame tracking on the link clock
    logic             fs_q, fs_qq;      // past frame sync samples
    logic             framed;           // first boundary seen
    logic [prx_pkg::POS_W-1:0] bit_cnt; // bit position in frame or half
    wire is_tdm = cfg_link.fmt == prx_pkg::PRX_FMT_TDM;
    wire is_lj  = cfg_link.fmt == prx_pkg::PRX_FMT_LJ;
    // I2S data lags the word select by one bit clock
    wire boundary = is_tdm ? (link_fsync & ~fs_q) :
                    is_lj  ? (link_fsync ^ fs_q) : (fs_q ^ fs_qq);
    wire half_right = is_lj ? ~link_fsync : fs_q;
    wire [prx_pkg::POS_W-1:0] pos = boundary ? '0 : bit_cnt;
    wire [prx_pkg::SLOT_W-1:0] slot_idx = pos[prx_pkg::POS_W-1 -: 5];
    // TDM counts slots straight through
    // I2S/LJ: left half 0..15, right half 16..31
    wire [prx_pkg::SLOT_W-1:0] cur_slot = is_tdm ? slot_idx :
                                          {half_right, slot_idx[3:0]};
    wire in_range = framed && (is_tdm || !slot_idx[4]);
    wire last_bit = &pos[prx_pkg::WORD_LOG-1:0];

    always_ff @(posedge link_clk or negedge link_rst_n) begin
        if (!link_rst_n) begin
            fs_q    <= 1'b0;
            fs_qq   <= 1'b0;
            framed  <= 1'b0;
            bit_cnt <= '0;
        end else begin
            fs_q    <= link_fsync;
            fs_qq   <= fs_q;
            bit_cnt <= pos + 1'b1;
            if (boundary) framed <= 1'b1;
        end
    end

    // one capture per channel; disabled channels never shift
    genvar g;
    generate
        for (g = 0; g < N; g++) begin : g_ch
            wire take = in_range && cur_slot == cfg_link.ch[g].slot &&
                        cfg_link.ch[g].dest != prx_pkg::PRX_DEST_NONE;
            prx_slot_capture u_cap (
                .clock        (clock),
                .arst_n       (arst_n),
                .sample       (sample[g]),
                .sample_valid (sample_valid[g]),
                .link_clk     (link_clk),
                .link_rst_n   (link_rst_n),
                .bit_in       (link_din),
                .hit          (take),
                .last         (last_bit),
                .dest         (cfg_link.ch[g].dest)
            );
        end
    endgenerate

    // checks: register side on clock, framing side on link_clk
    property p_ch4_enable;
        @(posedge clock) disable iff (!arst_n)
        reg_wr && hit4 |=> (route[0].dest == prx_pkg::PRX_DEST_PLAYBACK)
                           == $past(reg_wdata[5]);
    endproperty
    a_ch4_enable: assert property (p_ch4_enable)
        else $error("channel 4 enable does not follow bit 5");

    property p_slot_field;
        @(posedge clock) disable iff (!arst_n)
        reg_wr && hit6 |=> route[2].slot == $past(reg_wdata[4:0]);
    endproperty
    a_slot_field: assert property (p_slot_field)
        else $error("slot number not taken from bits 4 to 0");

    property p_half_slot;
        @(posedge link_clk) disable iff (!link_rst_n)
        !is_tdm && in_range |-> cur_slot[4] == half_right &&
                                cur_slot[3:0] == pos[8:5];
    endproperty
    a_half_slot: assert property (p_half_slot)
        else $error("left/right slot mapping wrong");

    property p_reset_slots;
        @(posedge clock) disable iff (!arst_n)
        !any_wr_seen |-> route[0].slot == 5'h03 && route[1].slot == 5'h04
                         && route[2].slot == 5'h05;
    endproperty
    a_reset_slots: assert property (p_reset_slots)
        else $error("slot defaults wrong after reset");

    property p_ch5_src;
        @(posedge clock) disable iff (!arst_n)
        reg_wr && hit5 && reg_wdata[6:5] == 2'h2 ##1 !(reg_wr && hit5)
        |-> route[1].dest == prx_pkg::PRX_DEST_LOOPBACK [*2];
    endproperty
    a_ch5_src: assert property (p_ch5_src)
        else $error("channel 5 loopback code not honoured");

    property p_ch6_link;
        @(posedge clock) disable iff (!arst_n)
        src6 == 2'h3 |-> route[2].dest == prx_pkg::PRX_DEST_LINK_DEV;
    endproperty
    a_ch6_link: assert property (p_ch6_link)
        else $error("channel 6 link code not honoured");

    property p_reset_off;
        @(posedge clock) disable iff (!arst_n)
        !any_wr_seen |-> sample_valid == 3'h0 &&
            route[0].dest == prx_pkg::PRX_DEST_NONE &&
            route[1].dest == prx_pkg::PRX_DEST_NONE &&
            route[2].dest == prx_pkg::PRX_DEST_NONE;
    endproperty
    a_reset_off: assert property (p_reset_off)
        else $error("a channel is live before any write");

    property p_reserved_zero;
        @(posedge clock) disable iff (!arst_n)
        // channel 4 reserves bits 7-6, channels 5 and 6 only bit 7
        (!$past(hit4) || reg_rdata[7:6] == 2'h0) &&
        (!$past(hit5 || hit6) || reg_rdata[7] == 1'b0);
    endproperty
    a_reserved_zero: assert property (p_reserved_zero)
        else $error("reserved bits read back nonzero");

    c_ch4_word:  cover property (@(posedge clock) sample_valid[0]);
    c_ch6_link:  cover property (@(posedge clock) sample_valid[2] &&
                     sample[2].dest == prx_pkg::PRX_DEST_LINK_DEV);
    c_right:     cover property (@(posedge link_clk) !is_tdm &&
                     in_range && half_right && last_bit);
endmodule
`default_nettype wire

// ### hdl/prx_pkg.sv
// prx_pkg: constants and types for the receive slot router, channels 4 to 6
package prx_pkg;
    // register map (8-bit control port)
    localparam logic [7:0] CH4_ROUTE_ADDR = 8'h2b;
    localparam logic [7:0] CH5_ROUTE_ADDR = 8'h2c;
    localparam logic [7:0] CH6_ROUTE_ADDR = 8'h2d;
    // reset values: slot 3/4/5, every channel disabled
    localparam logic [7:0] CH4_ROUTE_RST  = 8'h03;
    localparam logic [7:0] CH5_ROUTE_RST  = 8'h04;
    localparam logic [7:0] CH6_ROUTE_RST  = 8'h05;
    // writable bits; the upper reserved bits read back as zero
    localparam logic [7:0] CH4_WR_MASK    = 8'h3f;
    localparam logic [7:0] CH56_WR_MASK   = 8'h7f;
    // field positions
    localparam int ENABLE_BIT  = 5;
    localparam int SRC_LSB     = 5;
    localparam int SLOT_LSB    = 0;
    localparam int SLOT_W      = 5;
    // slot geometry on the link
    localparam int WORD_LOG    = 5;
    localparam int WORD_BITS   = 32;
    localparam int POS_W       = SLOT_W + WORD_LOG;
    localparam int NUM_CH      = 3;

    // destination of a received word
    typedef enum logic [1:0] {
        PRX_DEST_NONE     = 2'h0,
        PRX_DEST_PLAYBACK = 2'h1,
        PRX_DEST_LOOPBACK = 2'h2,
        PRX_DEST_LINK_DEV = 2'h3
    } prx_dest_t;

    // frame format of the serial port
    typedef enum logic [1:0] {
        PRX_FMT_TDM = 2'h0,
        PRX_FMT_I2S = 2'h1,
        PRX_FMT_LJ  = 2'h3
    } prx_fmt_t;

    // per channel route: where the data goes and which slot feeds it
    typedef struct packed {
        prx_dest_t         dest;
        logic [SLOT_W-1:0] slot;
    } prx_route_t;

    // everything the link side needs, moved as one word
    typedef struct packed {
        prx_fmt_t                 fmt;
        prx_route_t [NUM_CH-1:0]  ch;
    } prx_link_cfg_t;

    // one received word with its destination
    typedef struct packed {
        prx_dest_t            dest;
        logic [WORD_BITS-1:0] data;
    } prx_sample_t;
endpackage

// ### hdl/prx_slot_capture.sv
// prx_slot_capture: one channel's slot shifter and its crossing to clock
`timescale 1ns/100ps
`default_nettype none
module prx_slot_capture (
    // system side
    input  wire logic                 clock,
    input  wire logic                 arst_n,
    output var prx_pkg::prx_sample_t  sample,
    output logic                      sample_valid,
    // link side
    input  wire logic                 link_clk,
    input  wire logic                 link_rst_n,
    input  wire logic                 bit_in,
    input  wire logic                 hit,
    input  wire logic                 last,
    input  wire prx_pkg::prx_dest_t   dest
);
    logic [prx_pkg::WORD_BITS-2:0] shift;   // bits of the slot so far
    prx_pkg::prx_sample_t          hold;    // finished word, stable a frame
    logic                          tgl;     // flips once per finished word
    logic                          tgl_m1;  // first synchroniser stage
    logic                          tgl_m2;  // second synchroniser stage
    logic                          tgl_m3;  // edge detect history

    // link side: shift selected slot bits, publish at slot end
    always_ff @(posedge link_clk or negedge link_rst_n) begin
        if (!link_rst_n) begin
            shift <= '0;
            hold  <= '0;
            tgl   <= 1'b0;
        end else if (hit) begin
            shift <= {shift[prx_pkg::WORD_BITS-3:0], bit_in};
            if (last) begin
                hold <= '{dest: dest, data: {shift, bit_in}};
                tgl  <= ~tgl;
            end
        end
    end

    // system side: toggle crossing; hold is quiet for a whole frame
    // so it is settled long before the synchronised toggle arrives
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            tgl_m1       <= 1'b0;
            tgl_m2       <= 1'b0;
            tgl_m3       <= 1'b0;
            sample       <= '0;
            sample_valid <= 1'b0;
        end else begin
            tgl_m1       <= tgl;
            tgl_m2       <= tgl_m1;
            tgl_m3       <= tgl_m2;
            sample_valid <= tgl_m2 ^ tgl_m3;
            if (tgl_m2 ^ tgl_m3) begin
                sample <= hold;
            end
        end
    end
endmodule
`default_nettype wire

// ### tb/prx_link_host.sv
// prx_link_host: behavioural serial link master feeding the router
`timescale 1ns/100ps
`default_nettype none
module prx_link_host (
    // serial link toward the router
    output logic link_clk,
    output logic link_fsync,
    output logic link_din
);
    logic [31:0] words [0:31]; // slot words, right half from index 16

    initial begin
        link_clk   = 1'b0;
        link_fsync = 1'b0;
        link_din   = 1'b0;
    end

    // one bit: change while low, the router samples on the rise
    task automatic bit_out(input logic fs, input logic d);
        link_fsync = fs;
        link_din   = d;
        #24 link_clk = 1'b1;
        #24 link_clk = 1'b0;
    endtask

    // filler clocks, no boundary; lets the config crossing settle
    task automatic lead(input int n, input logic fs);
        repeat (n) bit_out(fs, ~link_din);
    endtask

    // one frame; the clock stands still before and after it
    task automatic frame(input prx_pkg::prx_fmt_t fmt, input int n);
        logic tdm;
        logic lj;
        logic fs;
        tdm = (fmt == prx_pkg::PRX_FMT_TDM);
        lj  = (fmt == prx_pkg::PRX_FMT_LJ);
        #0.7;
        lead(8, !(tdm || lj));
        for (int h = 0; h < (tdm ? 1 : 2); h++) begin
            // i2s: the half flag leads its first bit by one clock
            if (!tdm && !lj) bit_out(h[0], ~link_din);
            for (int s = 0; s < n; s++) begin
                for (int b = 31; b >= 0; b--) begin
                    fs = tdm ? (s == 0 && b == 31) : (lj ^ h[0]);
                    bit_out(fs, words[h * 16 + s][b]);
                end
            end
        end
        // released line: no pull, so it must not keep the last bit
        link_din = ~link_din;
    endtask
endmodule
`default_nettype wire

// ### tb/prx_router_tb.sv
// prx_router_tb: register and slot routing checks for channels 4 to 6
`timescale 1ns/100ps
`default_nettype none
module prx_router_tb;
    logic                        clock;
    logic                        arst_n;
    logic [7:0]                  reg_addr;
    logic                        reg_wr;
    logic [7:0]                  reg_wdata;
    logic [7:0]                  reg_rdata;
    prx_pkg::prx_fmt_t           frame_format;
    logic                        link_clk;
    logic                        link_fsync;
    logic                        link_din;
    prx_pkg::prx_sample_t [2:0]  sample;
    logic [2:0]                  sample_valid;
    int                          fails = 0;
    int                          n_checks = 0;
    int                          seed = 47169;
    int                          cnt [3];  // words seen per channel
    prx_pkg::prx_sample_t        got [3];  // last word per channel
    logic [1:0]                  code [3]; // source code per channel
    logic [4:0]                  slot [3]; // slot field per channel
    prx_pkg::prx_fmt_t           fmts [3] = '{prx_pkg::PRX_FMT_TDM,
        prx_pkg::PRX_FMT_I2S, prx_pkg::PRX_FMT_LJ};
    logic [7:0]                  addrs [3] = '{8'h2b, 8'h2c, 8'h2d};

    prx_router prx_router_inst (.clock(clock), .arst_n(arst_n),
        .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .frame_format(frame_format),
        .link_clk(link_clk), .link_fsync(link_fsync),
        .link_din(link_din), .sample(sample),
        .sample_valid(sample_valid));
    prx_link_host prx_link_host_inst (.link_clk(link_clk),
        .link_fsync(link_fsync), .link_din(link_din));

    // 250 MHz system clock
    initial begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end

    // words captured per channel, one valid pulse each
    always @(posedge clock) begin
        for (int c = 0; c < 3; c++) begin
            if (sample_valid[c] === 1'b1) begin
                cnt[c] = cnt[c] + 1;
                got[c] = sample[c];
            end
        end
    end

    task automatic check(input logic [39:0] seen, input logic [39:0] exp);
        n_checks++;
        if (seen !== exp) begin
            fails++;
            $display("BAD %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic results();
        $display("checks %0d fails %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // one write, strobe for a single cycle
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock) #1;
        reg_addr  = a;
        reg_wdata = d;
        reg_wr    = 1'b1;
        @(posedge clock) #1;
        reg_wr    = 1'b0;
    endtask

    // read data is registered: one cycle after the address
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clock) #1;
        reg_addr = a;
        @(posedge clock) #1;
        check(reg_rdata, exp);
    endtask

    // words expected: disabled or out-of-range slots give none
    function automatic int exp_cnt(input prx_pkg::prx_fmt_t f,
        input logic [4:0] v, input int n, input logic [1:0] c);
        if (c == 2'h0) return 0;
        if (f == prx_pkg::PRX_FMT_TDM) return (v < n) ? 1 : 0;
        return (v[3:0] < n) ? 1 : 0;
    endfunction

    // program the three routes, send one frame, compare
    task automatic trial(input prx_pkg::prx_fmt_t f, input int n);
        int e;
        for (int i = 0; i < 32; i++) begin
            prx_link_host_inst.words[i] = $random(seed);
        end
        frame_format = f;
        wr(addrs[0], {2'h0, code[0][0], slot[0]});
        wr(addrs[1], {1'h0, code[1], slot[1]});
        wr(addrs[2], {1'h0, code[2], slot[2]});
        cnt = '{0, 0, 0};
        prx_link_host_inst.frame(f, n);
        repeat (12) @(posedge clock);
        for (int c = 0; c < 3; c++) begin
            e = exp_cnt(f, slot[c], n, code[c]);
            check(cnt[c], e);
            // the slot field is also the word index for every framing
            if (e == 1) check(got[c],
                {code[c], prx_link_host_inst.words[slot[c]]});
        end
    endtask

    // watchdog: frames need about 260 us, stay under 100k clocks
    initial begin
        #350000;
        fails++;
        results();
    end

    initial begin
        arst_n = 1'b0;
        reg_addr = 8'h00;
        reg_wr = 1'b0;
        reg_wdata = 8'h00;
        frame_format = prx_pkg::PRX_FMT_TDM;
        prx_link_host_inst.lead(4, 1'b0);
        check({sample_valid, reg_rdata}, 11'h000);
        repeat (12) @(posedge clock);
        #1 arst_n = 1'b1;
        rd(addrs[0], prx_pkg::CH4_ROUTE_RST);
        rd(addrs[1], prx_pkg::CH5_ROUTE_RST);
        rd(addrs[2], prx_pkg::CH6_ROUTE_RST);
        // reserved bits set on purpose: they must read back zero
        wr(addrs[0], 8'hff);
        wr(addrs[1], 8'hdf);
        wr(addrs[2], 8'hff);
        wr(8'h2e, 8'hff);
        rd(addrs[0], 8'h3f);
        rd(addrs[1], 8'h5f);
        rd(addrs[2], 8'h7f);
        rd(8'h2e, 8'h00);
        rd(8'h2a, 8'h00);
        // corners: last tdm slot, both half edges, right out of range
        code = '{2'h1, 2'h1, 2'h3};
        slot = '{5'd31, 5'd0, 5'd16};
        trial(prx_pkg::PRX_FMT_TDM, 32);
        code = '{2'h1, 2'h2, 2'h2};
        slot = '{5'd15, 5'd16, 5'd31};
        trial(prx_pkg::PRX_FMT_I2S, 16);
        code = '{2'h0, 2'h1, 2'h1};
        slot = '{5'd3, 5'd20, 5'd19};
        trial(prx_pkg::PRX_FMT_LJ, 4);
        for (int t = 0; t < 3; t++) begin
            code[0] = $random(seed) & 1;
            // reserved channel 5 code left out of random traffic
            code[1] = ($random(seed) & 32'h7fffffff) % 3;
            code[2] = $random(seed) & 3;
            for (int c = 0; c < 3; c++) slot[c] = $random(seed) & 31;
            trial(fmts[t], (t == 0) ? 32 : ($random(seed) & 15) + 1);
        end
        results();
    end
endmodule
`default_nettype wire
